// [liu_alarm_pkg.sv]
/*
  Package for the LIU alarm and monitor block: channel count, timing
  counts, reset values and the per-channel carrier structs.
  Assumes a single 125 MHz system clock.
*/
package liu_alarm_pkg;

  localparam int unsigned NUM_CH         = 8;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned MISS_LIMIT     = 128;
  localparam int unsigned MISS_CNT_W     = 8;
  localparam int unsigned RESET_HOLD_US  = 10;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ + 1;
  localparam int unsigned RESET_CNT_W    = 11;
  localparam int unsigned SYNTH_DIV_W    = 32;
  localparam logic [31:0] SYNTH_PHASE_INC = 32'h0431BDE8;
  localparam logic        IRQ_EN_RST     = 1'b0;
  localparam logic        AAO_EN_RST     = 1'b0;
  localparam logic        DMO_RST        = 1'b0;

  typedef struct packed {
    logic loss_of_signal;
    logic tx_data_p;
    logic tx_data_n;
  } ch_in_t;

  typedef struct packed {
    logic line_p;
    logic line_n;
  } line_out_t;

endpackage

// [liu_dmo_channel.sv]
/*
  One channel of driver monitoring: counts transmit clock ticks without
  a pulse on the line pair and raises the monitor flag past the limit.
  Assumes tick is a one-cycle enable, one per transmit clock period.
*/
`timescale 1ns/100ps
`default_nettype none
module liu_dmo_channel
  import liu_alarm_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  wire logic  tick,
  input  wire logic  pulse_seen,
  output logic       dmo
);

  logic [MISS_CNT_W-1:0] miss_r;
  logic                  dmo_r;
  wire                   over_limit = (miss_r >= MISS_CNT_W'(MISS_LIMIT));

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      miss_r <= '0;
      dmo_r  <= DMO_RST;
    end
    else if (tick)
    begin
      if (pulse_seen)
      begin
        miss_r <= '0;
        dmo_r  <= 1'b0;
      end
      else
      begin
        if (!over_limit)
          miss_r <= miss_r + MISS_CNT_W'(1);
        // Held at least one tick, since only a tick with a pulse clears it
        if (over_limit)
          dmo_r <= 1'b1;
      end
    end
  end

  assign dmo = dmo_r;

endmodule
`default_nettype wire

// [liu_alarm_monitor_control.sv]
/*
  Alarm and monitor control of an eight-channel E1 line interface:
  automatic all-ones on loss of signal, alarm interrupt, driver monitor
  outputs, reset stretch and synthesized E1 clock.
  Assumes pins are asynchronous to clk and resynchronised here; the host
  side presents config bits and a status-read strobe on clk.
*/
// Operation
// - Host-mode processor logic clocked by the synchronous processor clock.
// - Hardware mode: auto all-ones pin sends all-ones on channels losing signal.
// - Host mode: a global config bit enables auto all-ones instead.
// - Interrupt driven low on any alarm status change when enabled.
// - Interrupt released high once host reads the pending status.
// - Interrupts only generated while global interrupt enable is set.
// - Monitor flag rises after more than 128 transmit clocks without pulse.
// - Monitor flag stays high at least one transmit clock.
// - Monitor flag drops when the transmitter sends a valid pulse.
// - Synthesized E1-rate master clock driven out on its own pin.
// - Reset held low over 10 us restores all registers to defaults.
`timescale 1ns/100ps
`default_nettype none
module liu_alarm_monitor_control
  import liu_alarm_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               host_mode,
  input  wire logic               up_clk_aao_pin,
  input  wire logic               auto_all_ones_on_loss,
  input  wire logic               global_irq_enable,
  input  wire logic               status_read,
  input  wire logic               hw_reset_b,
  input  wire logic               e1_reference_clock_in,
  input  wire logic               transmit_line_clock,
  input  wire ch_in_t [NUM_CH-1:0] ch_in,
  output line_out_t [NUM_CH-1:0]  line_transmit_pair,
  output logic [NUM_CH-1:0]       driver_monitor_out,
  output logic                    irq_out,
  output logic                    irq_oe,
  output logic                    up_clk_tick,
  output logic                    synth_master_clock_out,
  output logic [NUM_CH-1:0]       alarm_status,
  output logic [NUM_CH-1:0]       alarm_change
);

  // Three-stage synchronisers for all pin inputs
  logic [2:0] pin_s_r;
  logic [2:0] hrst_s_r;
  logic [2:0] ref_s_r;
  logic [2:0] transmit_line_clock_s_r;
  logic [2:0] los_s_r [NUM_CH];
  logic [2:0] txp_s_r [NUM_CH];
  logic [2:0] txn_s_r [NUM_CH];

  always_ff @(posedge clk)
  begin
    pin_s_r  <= {pin_s_r[1:0], up_clk_aao_pin};
    hrst_s_r <= {hrst_s_r[1:0], hw_reset_b};
    ref_s_r  <= {ref_s_r[1:0], e1_reference_clock_in};
    transmit_line_clock_s_r <= {transmit_line_clock_s_r[1:0], transmit_line_clock};
    for (int i = 0; i < NUM_CH; i++)
    begin
      los_s_r[i] <= {los_s_r[i][1:0], ch_in[i].loss_of_signal};
      txp_s_r[i] <= {txp_s_r[i][1:0], ch_in[i].tx_data_p};
      txn_s_r[i] <= {txn_s_r[i][1:0], ch_in[i].tx_data_n};
    end
  end

  // Debounced levels: a change counts when stages two and three agree
  logic       pin_r;
  logic       hrst_lvl_r;
  logic       ref_r;
  logic       transmit_line_clock_r;
  logic [NUM_CH-1:0] los_r;
  logic [NUM_CH-1:0] txp_r;
  logic [NUM_CH-1:0] txn_r;
  logic       pin_d_r;
  logic       ref_d_r;
  logic       transmit_line_clock_d_r;
  wire        pin_agree  = (pin_s_r[1] == pin_s_r[2]);
  wire        hrst_agree = (hrst_s_r[1] == hrst_s_r[2]);
  wire        ref_agree  = (ref_s_r[1] == ref_s_r[2]);
  wire        transmit_line_clock_agree = (transmit_line_clock_s_r[1] == transmit_line_clock_s_r[2]);

  // Edge detectors start at the pin's level, so leaving reset makes no false edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pin_r      <= pin_s_r[2];
      hrst_lvl_r <= 1'b1;
      ref_r      <= ref_s_r[2];
      transmit_line_clock_r     <= transmit_line_clock_s_r[2];
      pin_d_r    <= pin_s_r[2];
      ref_d_r    <= ref_s_r[2];
      transmit_line_clock_d_r   <= transmit_line_clock_s_r[2];
    end
    else
    begin
      if (pin_agree)
        pin_r <= pin_s_r[2];
      if (hrst_agree)
        hrst_lvl_r <= hrst_s_r[2];
      if (ref_agree)
        ref_r <= ref_s_r[2];
      if (transmit_line_clock_agree)
        transmit_line_clock_r <= transmit_line_clock_s_r[2];
      pin_d_r  <= pin_r;
      ref_d_r  <= ref_r;
      transmit_line_clock_d_r <= transmit_line_clock_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      los_r <= '0;
      txp_r <= '0;
      txn_r <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (los_s_r[i][1] == los_s_r[i][2])
          los_r[i] <= los_s_r[i][2];
        if (txp_s_r[i][1] == txp_s_r[i][2])
          txp_r[i] <= txp_s_r[i][2];
        if (txn_s_r[i][1] == txn_s_r[i][2])
          txn_r[i] <= txn_s_r[i][2];
      end
    end
  end

  // Hardware reset stretch: short glitches on the pin do not clear state
  logic [RESET_CNT_W-1:0] hrst_cnt_r;
  logic                   hrst_fire_r;
  wire                    hrst_done = (hrst_cnt_r >= RESET_CNT_W'(RESET_HOLD_CYC));

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hrst_cnt_r  <= '0;
      hrst_fire_r <= 1'b0;
    end
    else if (hrst_lvl_r)
    begin
      hrst_cnt_r  <= '0;
      hrst_fire_r <= 1'b0;
    end
    else
    begin
      if (!hrst_done)
        hrst_cnt_r <= hrst_cnt_r + RESET_CNT_W'(1);
      hrst_fire_r <= hrst_done;
    end
  end

  wire soft_rst_b = rst_b & ~hrst_fire_r;

  // Processor clock tick taken from the shared pin in host mode only
  // Tick lags the pin by the synchroniser, so host strobes must outlast it
  wire   pin_rise    = pin_r & ~pin_d_r;
  assign up_clk_tick = host_mode & pin_rise;

  // Latched host configuration, updated on processor clock ticks
  logic aao_cfg_r;
  logic irq_en_r;

  always_ff @(posedge clk)
  begin
    if (!soft_rst_b)
    begin
      aao_cfg_r <= AAO_EN_RST;
      irq_en_r  <= IRQ_EN_RST;
    end
    else if (up_clk_tick)
    begin
      aao_cfg_r <= auto_all_ones_on_loss;
      irq_en_r  <= global_irq_enable;
    end
  end

  // All-ones select: pin in hardware mode, register in host mode
  wire aao_active = host_mode ? aao_cfg_r : pin_r;
  wire [NUM_CH-1:0] force_ones = {NUM_CH{aao_active}} & los_r;

  // Line drivers: all-ones on the bipolar pair means alternating marks
  logic              mark_phase_r;
  line_out_t [NUM_CH-1:0] line_r;
  wire               transmit_line_clock_tick = transmit_line_clock_r & ~transmit_line_clock_d_r;

  always_ff @(posedge clk)
  begin
    if (!soft_rst_b)
    begin
      mark_phase_r <= 1'b0;
      line_r       <= '0;
    end
    else if (transmit_line_clock_tick)
    begin
      mark_phase_r <= ~mark_phase_r;
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (force_ones[i])
        begin
          line_r[i].line_p <= ~mark_phase_r;
          line_r[i].line_n <= mark_phase_r;
        end
        else
        begin
          line_r[i].line_p <= txp_r[i];
          line_r[i].line_n <= txn_r[i];
        end
      end
    end
  end

  assign line_transmit_pair = line_r;

  // Driver monitors watch what actually leaves the driver
  wire [NUM_CH-1:0] pulse_seen;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : gen_dmo
      // A mark on either rail counts as a transmitted pulse
      assign pulse_seen[g] = line_r[g].line_p | line_r[g].line_n;
      liu_dmo_channel u_dmo (
        .clk        (clk),
        .rst_b      (soft_rst_b),
        .tick       (transmit_line_clock_tick),
        .pulse_seen (pulse_seen[g]),
        .dmo        (driver_monitor_out[g])
      );
    end
  endgenerate

  // Alarm status and sticky change flags
  logic [NUM_CH-1:0] status_r;
  logic [NUM_CH-1:0] change_r;
  wire  [NUM_CH-1:0] status_nxt = los_r | driver_monitor_out;
  // Either direction of a status change counts as an alarm event
  wire  [NUM_CH-1:0] change_evt = status_nxt ^ status_r;
  wire               read_tick  = host_mode & status_read & up_clk_tick;
  wire  [NUM_CH-1:0] change_keep = read_tick ? '0 : change_r;

  always_ff @(posedge clk)
  begin
    if (!soft_rst_b)
    begin
      status_r <= '0;
      change_r <= '0;
    end
    else
    begin
      status_r <= status_nxt;
      // Set beats clear so a change during the read is kept
      change_r <= change_keep | change_evt;
    end
  end

  assign alarm_status = status_r;
  assign alarm_change = change_r;

  // Open-drain interrupt: drive low only while enabled and pending
  wire any_change  = |change_r;
  wire irq_pending = host_mode & irq_en_r & any_change;
  assign irq_out = 1'b0;
  assign irq_oe  = irq_pending;

  // E1-rate clock from a phase accumulator, locked to the reference edges
  logic [SYNTH_DIV_W-1:0] phase_r;
  wire                    ref_rise = ref_r & ~ref_d_r;
  // Re-align only late in the high half, so a stray edge cannot cut it short
  wire                    phase_late = &phase_r[SYNTH_DIV_W-1 -: 2];

  always_ff @(posedge clk)
  begin
    if (!soft_rst_b)
      phase_r <= '0;
    else if (ref_rise & phase_late)
      phase_r <= '0;
    else
      phase_r <= phase_r + SYNTH_PHASE_INC;
  end

  logic mclk_r;

  always_ff @(posedge clk)
  begin
    if (!soft_rst_b)
      mclk_r <= 1'b0;
    else
      mclk_r <= phase_r[SYNTH_DIV_W-1];
  end

  assign synth_master_clock_out = mclk_r;

endmodule
`default_nettype wire

// [liu_alarm_properties.sv]
/*
  Checker on the ports of the alarm and monitor block.
  Assumes a transmit clock of 8 clk cycles and a pulled-up interrupt line.
*/
`timescale 1ns/100ps
`default_nettype none
module liu_alarm_properties
  import liu_alarm_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   host_mode,
  input wire logic                   up_clk_aao_pin,
  input wire logic                   hw_reset_b,
  input wire logic                   transmit_line_clock,
  input wire line_out_t [NUM_CH-1:0] line_transmit_pair,
  input wire logic [NUM_CH-1:0]      driver_monitor_out,
  input wire logic                   irq_oe,
  input wire logic                   up_clk_tick,
  input wire logic                   synth_master_clock_out,
  input wire logic [NUM_CH-1:0]      alarm_change
);
  logic       tlc_r;
  logic [7:0] idle_r;
  // Raw edges lead the design's synchronised ticks, so the count is an upper view
  always_ff @(posedge clk)
  begin
    tlc_r <= transmit_line_clock;
    if (!rst_b || |line_transmit_pair[0])
      idle_r <= 8'h00;
    else if (transmit_line_clock && !tlc_r && idle_r != 8'hFF)
      idle_r <= idle_r + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !hw_reset_b);
  sequence dmo_rise; $rose(driver_monitor_out[0]); endsequence
  sequence dmo_hold; driver_monitor_out[0] [*8]; endsequence
  AST_TICK_HOST: assert property (up_clk_tick |-> host_mode)
    else $error("processor tick in hardware mode");
  AST_TICK_LAT: assert property ($rose(up_clk_aao_pin) && host_mode |-> ##4 up_clk_tick)
    else $error("processor tick late");
  AST_IRQ_CAUSE: assert property (irq_oe |-> host_mode && alarm_change != 8'h00)
    else $error("interrupt without pending change");
  AST_IRQ_REL: assert property ($fell(irq_oe) |-> $past(up_clk_tick))
    else $error("interrupt released without read");
  AST_DMO_CNT: assert property (dmo_rise |-> idle_r >= 8'h80)
    else $error("monitor flag raised early");
  AST_DMO_MIN: assert property (dmo_rise |-> dmo_hold)
    else $error("monitor flag too short");
  AST_DMO_CLR: assert property ($fell(driver_monitor_out[0]) |-> |$past(line_transmit_pair[0]))
    else $error("monitor flag cleared without pulse");
  AST_SYNTH: assert property ($changed(synth_master_clock_out) |=> $stable(synth_master_clock_out) [*8])
    else $error("synth clock half period short");
endmodule
bind liu_alarm_monitor_control liu_alarm_properties liu_alarm_properties_inst (
  .clk, .rst_b, .host_mode, .up_clk_aao_pin, .hw_reset_b, .transmit_line_clock,
  .line_transmit_pair, .driver_monitor_out, .irq_oe, .up_clk_tick,
  .synth_master_clock_out, .alarm_change);
`default_nettype wire

// [host_partner_model.sv]
/*
  Host processor model: processor clock or all-ones pin, config bits, status reads.
  Assumes irq_n already carries the pull-up level of the interrupt line.
*/
`timescale 1ns/100ps
`default_nettype none
module host_partner_model
(
  input  wire logic clk,
  input  wire logic host_mode,
  input  wire logic hw_pin,
  input  wire logic want_aao,
  input  wire logic want_irq,
  input  wire logic read_en,
  input  wire logic irq_n,
  output logic      up_clk_aao_pin,
  output logic      auto_all_ones_on_loss,
  output logic      global_irq_enable,
  output logic      status_read
);
  logic [3:0] div_r = 4'h0;
  initial status_read = 1'b0;
  // Read changes as the processor clock falls, well after the block's delayed tick
  always @(negedge clk)
  begin
    div_r <= div_r + 4'h1;
    if (div_r == 4'hF)
      status_read <= read_en && !irq_n;
  end
  assign up_clk_aao_pin = host_mode ? div_r[3] : hw_pin;
  assign auto_all_ones_on_loss = want_aao;
  assign global_irq_enable = want_irq;
endmodule
`default_nettype wire

// [testbench.sv]
/*
  Self-checking bench for the alarm and monitor block.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import liu_alarm_pkg::*;
  logic clk, rst_b, host_mode, hw_pin, want_aao, want_irq, read_en, hw_reset_b;
  logic e1_reference_clock_in, transmit_line_clock, irq_n, irq_out, irq_oe, up_clk_tick;
  logic up_clk_aao_pin, auto_all_ones_on_loss, global_irq_enable, status_read;
  logic synth_master_clock_out, prev;
  ch_in_t [NUM_CH-1:0]    ch_in;
  line_out_t [NUM_CH-1:0] line_transmit_pair;
  logic [NUM_CH-1:0]      driver_monitor_out, alarm_status, alarm_change;
  int                     err_total, samples_checked, n, m, i;
  // host, pin, config bit, loss, all-ones expected
  logic [4:0] rows [5] = '{5'b10111, 5'b10010, 5'b01011, 5'b00110, 5'b01100};
  always #4 clk = ~clk;
  always #32 transmit_line_clock = ~transmit_line_clock;
  always
  begin
    repeat (30) @(negedge clk);
    e1_reference_clock_in = ~e1_reference_clock_in;
    repeat (31) @(negedge clk);
    e1_reference_clock_in = ~e1_reference_clock_in;
  end
  assign irq_n = irq_oe ? irq_out : 1'b1;
  host_partner_model host_partner_model_inst (.clk, .host_mode, .hw_pin, .want_aao,
    .want_irq, .read_en, .irq_n, .up_clk_aao_pin, .auto_all_ones_on_loss,
    .global_irq_enable, .status_read);
  liu_alarm_monitor_control liu_alarm_monitor_control_inst (.clk, .rst_b, .host_mode,
    .up_clk_aao_pin, .auto_all_ones_on_loss, .global_irq_enable, .status_read,
    .hw_reset_b, .e1_reference_clock_in, .transmit_line_clock, .ch_in,
    .line_transmit_pair, .driver_monitor_out, .irq_out, .irq_oe, .up_clk_tick,
    .synth_master_clock_out, .alarm_status, .alarm_change);
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rst();
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(8 * 20000);
    err_total++;
    final_report();
  end
  initial
  begin
    {clk, host_mode, hw_pin, want_aao, want_irq, read_en, e1_reference_clock_in} = 7'h00;
    {transmit_line_clock, hw_reset_b, ch_in, err_total, samples_checked} = '0;
    hw_reset_b = 1'b1;
    foreach (rows[r])
    begin
      {host_mode, hw_pin, want_aao, ch_in[0].loss_of_signal} = rows[r][4:1];
      rst();
      repeat (80) @(negedge clk);
      {n, m} = '0;
      repeat (64)
      begin
        @(negedge clk);
        n += |line_transmit_pair[0];
        m += |line_transmit_pair[1];
      end
      chk("all_ones", {7'h00, rows[r][0]}, {7'h00, n != 0});
      chk("ch1_line", 8'h00, {7'h00, m != 0});
    end
    ch_in = '0;
    ch_in[1].tx_data_p = 1'b1;
    {host_mode, hw_pin} = 2'h0;
    rst();
    repeat (960) @(negedge clk);
    chk("dmo_early", 8'h00, driver_monitor_out);
    for (i = 0; i < 300 && driver_monitor_out[0] !== 1'b1; i++) @(negedge clk);
    chk("dmo_set", 8'hFD, driver_monitor_out);
    @(negedge clk);
    chk("alarm_status", 8'hFD, alarm_status);
    ch_in[0].tx_data_p = 1'b1;
    repeat (4) @(negedge clk);
    chk("dmo_hold", 8'h01, {7'h00, driver_monitor_out[0]});
    for (i = 0; i < 60 && driver_monitor_out[0] !== 1'b0; i++) @(negedge clk);
    chk("dmo_clear", 8'hFC, driver_monitor_out);
    hw_reset_b = 1'b0;
    repeat (1000) @(negedge clk);
    chk("hw_reset_short", 8'hFC, driver_monitor_out);
    repeat (300) @(negedge clk);
    chk("hw_reset_long", 8'h00, driver_monitor_out);
    hw_reset_b = 1'b1;
    ch_in = {NUM_CH{3'b010}};
    host_mode = 1'b1;
    rst();
    repeat (40) @(negedge clk);
    ch_in[2].loss_of_signal = 1'b1;
    repeat (100) @(negedge clk);
    chk("irq_disabled", 8'h01, {7'h00, irq_n});
    chk("change", 8'h04, alarm_change);
    want_irq = 1'b1;
    repeat (40) @(negedge clk);
    chk("irq_enabled", 8'h00, {7'h00, irq_n});
    read_en = 1'b1;
    repeat (60) @(negedge clk);
    chk("irq_release", 8'h01, {7'h00, irq_n});
    chk("change_clear", 8'h00, alarm_change);
    {n, prev} = '0;
    repeat (80)
    begin
      @(negedge clk);
      n += up_clk_tick;
    end
    chk("ticks", 8'h05, n[7:0]);
    n = 0;
    prev = synth_master_clock_out;
    repeat (610)
    begin
      @(negedge clk);
      n += synth_master_clock_out ^ prev;
      prev = synth_master_clock_out;
    end
    chk("synth_rate", 8'h01, {7'h00, n >= 19 && n <= 21});
    final_report();
  end
endmodule
`default_nettype wire
